// ==== hw/prd_pkg.sv ====
package prd_pkg;
   localparam int LANE_W = 32;
   localparam int REG_W = 64;
   localparam int NUM_REGS = 8;
   localparam int REG_IDX_W = 3;
   localparam int LUT_IDX_W = 7;
   localparam int LUT_DEPTH = 128;
   localparam int APPROX_LAT = 3;
   localparam int MUL_LAT = 4;
   localparam int MANT_W = 24;
   localparam int EXP_BIAS = 127;
   localparam logic [2:0] LAT_CNT_W = 3'h3;
   localparam logic [REG_W-1:0] REG_RST_VAL = 64'h0000000000000000;
   typedef enum logic [3:0] {
      PRD_OP_NOP = 4'h0,
      PRD_OP_RECIP_APPROX = 4'h1,
      PRD_OP_RSQRT_APPROX = 4'h2,
      PRD_OP_RECIP_STEP1 = 4'h3,
      PRD_OP_RECIP_STEP2 = 4'h4,
      PRD_OP_RSQRT_STEP1 = 4'h5,
      PRD_OP_FMUL = 4'h6,
      PRD_OP_WMADD = 4'h7,
      PRD_OP_UNPACK_LO = 4'h8,
      PRD_OP_LOAD = 4'h9,
      PRD_OP_STATE_CLR = 4'ha,
      PRD_OP_FAST_CLR = 4'hb,
      PRD_OP_LEGACY_WR = 4'hc
   } prd_op_e;
endpackage

// ==== hw/prd_lane.sv ====
`timescale 1ns/10ps
// one 32-bit single-precision lane, purely combinational
module prd_lane
   import prd_pkg::*;
(
   input wire logic [3:0] op_i,
   input wire logic [LANE_W-1:0] a_i,
   input wire logic [LANE_W-1:0] b_i,
   output logic [LANE_W-1:0] res_o
);
   // single-precision multiply, round to nearest even, flush denormals
   function automatic logic [31:0] fmul(input logic [31:0] x,
                                        input logic [31:0] y);
      logic s;
      logic [9:0] e;
      logic [47:0] p;
      logic [23:0] m;
      logic g;
      logic st;
      logic [24:0] r;
      s = x[31] ^ y[31];
      p = {1'b1, x[22:0]} * {1'b1, y[22:0]};
      if (x[30:23] == 8'h00 || y[30:23] == 8'h00) begin
         fmul = {s, 31'h0};
      end else begin
         e = 10'(x[30:23]) + 10'(y[30:23]) - 10'(EXP_BIAS);
         if (p[47]) begin
            m = p[47:24];
            g = p[23];
            st = |p[22:0];
            e = e + 10'h001;
         end else begin
            m = p[46:23];
            g = p[22];
            st = |p[21:0];
         end
         r = {1'b0, m} + 25'(g & (st | m[0]));
         if (r[24]) begin
            r = r >> 1;
            e = e + 10'h001;
         end
         if (e[9] || e == 10'h000) begin
            fmul = {s, 31'h0};
         end else if (e >= 10'h0ff) begin
            fmul = {s, 8'hff, 23'h0};
         end else begin
            fmul = {s, e[7:0], r[22:0]};
         end
      end
   endfunction

   // single-precision add/sub of like-or-unlike signs, truncating align
   function automatic logic [31:0] fadd(input logic [31:0] x,
                                        input logic [31:0] y);
      logic [31:0] big;
      logic [31:0] sml;
      logic [7:0] d;
      logic [26:0] mb;
      logic [26:0] ms;
      logic [27:0] sum;
      logic [8:0] e;
      int i;
      int lz;
      if (x[30:0] >= y[30:0]) begin
         big = x;
         sml = y;
      end else begin
         big = y;
         sml = x;
      end
      d = big[30:23] - sml[30:23];
      mb = {1'b1, big[22:0], 3'b000};
      ms = (sml[30:23] == 8'h00 || d > 8'd26) ? 27'h0 :
           ({1'b1, sml[22:0], 3'b000} >> d);
      e = {1'b0, big[30:23]};
      if (big[31] == sml[31]) begin
         sum = {1'b0, mb} + {1'b0, ms};
      end else begin
         sum = {1'b0, mb} - {1'b0, ms};
      end
      lz = 0;
      for (i = 27; i >= 0; i--) begin
         if (sum[i] && lz == 0) begin
            lz = 28 - i;
         end
      end
      if (big[30:23] == 8'h00 || sum == 28'h0) begin
         fadd = (big[30:23] == 8'h00) ? sml : 32'h0;
      end else if (lz == 1) begin
         fadd = {big[31], 8'(e + 9'h001), sum[26:4]};
      end else if (9'(lz - 2) >= e) begin
         fadd = {big[31], 31'h0};
      end else begin
         sum = sum << (lz - 1);
         fadd = {big[31], 8'(e - 9'(lz - 2)), sum[26:4]};
      end
   endfunction

   // computed estimates, no table: recip by full divide, rsqrt by seed and iterations
   function automatic logic [31:0] recip_est(input logic [31:0] x);
      logic [7:0] ne;
      logic [23:0] q;
      logic [47:0] t;
      t = 48'h800000000000 / 48'({1'b1, x[22:0]});
      q = t[23:0];
      if (x[30:23] >= 8'hfd) begin
         recip_est = {x[31], 31'h0};
      end else if (x[30:23] == 8'h00) begin
         recip_est = {x[31], 8'hff, 23'h0};
      end else if (x[22:0] == 23'h0) begin
         ne = 8'd254 - x[30:23];
         recip_est = {x[31], ne, 23'h0};
      end else begin
         ne = 8'd253 - x[30:23];
         recip_est = {x[31], ne, q[22:8], 8'h00};
      end
   endfunction

   function automatic logic [31:0] rsqrt_est(input logic [31:0] x);
      logic [31:0] y;
      logic [31:0] h;
      logic [31:0] t;
      int k;
      // seed then two internal rsqrt iterations give >= 15 bits
      y = 32'h5f3759df - {1'b0, x[30:1]};
      h = {x[31], 8'(x[30:23] - 8'h01), x[22:0]};
      t = 32'h0;
      for (k = 0; k < 2; k++) begin
         t = fmul(h, fmul(y, y));
         y = fmul(y, fadd(32'h3fc00000, {~t[31], t[30:0]}));
      end
      if (x[30:23] == 8'h00) begin
         rsqrt_est = {1'b0, 8'hff, 23'h0};
      end else begin
         rsqrt_est = {1'b0, y[30:8], 8'h00};
      end
   endfunction

   logic [31:0] prod_ab;
   // recip step1 keeps b*z; step2 finishes z*(2-b*z)
   assign prod_ab = fmul(a_i, b_i);

   always_comb begin
      case (op_i)
         4'h1: res_o = recip_est(a_i);
         4'h2: res_o = rsqrt_est(a_i);
         4'h3: res_o = prod_ab;
         4'h4: res_o = fmul(b_i, fadd(32'h40000000,
                              {~a_i[31], a_i[30:0]}));
         4'h5: res_o = prod_ab;
         4'h6: res_o = prod_ab;
         default: res_o = a_i;
      endcase
   end
endmodule

// ==== hw/prd_datapath.sv ====
`timescale 1ns/10ps
// What this block does
// - reciprocal estimate by divide, three-cycle latency
// - rsqrt estimate good to fifteen bits
// - one Newton step gives full precision
// - refined reciprocal nearly always correctly rounded
// - refined rsqrt within one ulp
// - square root is rsqrt times input
// - fast divide sequence takes seven cycles
// - full divide sequence takes fifteen cycles
// - paired pipelined divides take 21 cycles
// - fast square root seven cycles, rsqrt four less
// - full square root takes nineteen cycles
// - packed ops process two values at once
// - registers addressed by number, no stack
// - register file shared with legacy unit
// - no penalty switching legacy and packed
// - fast clear is alias of clear
// - word multiply-add: four products, pairwise sums
module prd_datapath
   import prd_pkg::*;
(
   // clock and reset
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   // issue
   input wire logic ISSUE_VALID_I,
   input wire logic [3:0] ISSUE_OP_I,
   input wire logic [REG_IDX_W-1:0] ISSUE_DST_I,
   input wire logic [REG_IDX_W-1:0] ISSUE_SRC_I,
   input wire logic [REG_W-1:0] ISSUE_LOAD_DATA_I,
   output logic ISSUE_READY_O,
   // register read port
   input wire logic [REG_IDX_W-1:0] RD_IDX_I,
   output logic [REG_W-1:0] RD_DATA_O,
   // status
   output logic MM_STATE_O,
   output logic BUSY_O,
   output logic WB_VALID_O,
   output logic [REG_IDX_W-1:0] WB_IDX_O
);
   // shared architectural registers, written by both units
   logic [REG_W-1:0] regs_ff [NUM_REGS];
   logic mm_state_ff;
   logic [REG_W-1:0] pipe_ff [MUL_LAT];
   logic [MUL_LAT-1:0] pv_ff;
   logic [REG_IDX_W-1:0] pdst_ff [MUL_LAT];
   logic [MUL_LAT-1:0] pshort_ff;

   // operand fetch by register number
   wire [REG_W-1:0] opa = regs_ff[ISSUE_DST_I];
   wire [REG_W-1:0] opb = regs_ff[ISSUE_SRC_I];
   wire is_approx = (ISSUE_OP_I == PRD_OP_RECIP_APPROX) ||
                    (ISSUE_OP_I == PRD_OP_RSQRT_APPROX);
   wire is_arith = is_approx ||
                   (ISSUE_OP_I == PRD_OP_RECIP_STEP1) ||
                   (ISSUE_OP_I == PRD_OP_RECIP_STEP2) ||
                   (ISSUE_OP_I == PRD_OP_RSQRT_STEP1) ||
                   (ISSUE_OP_I == PRD_OP_FMUL) ||
                   (ISSUE_OP_I == PRD_OP_WMADD);
   wire is_clr = (ISSUE_OP_I == PRD_OP_STATE_CLR) ||
                 (ISSUE_OP_I == PRD_OP_FAST_CLR);
   wire is_single = (ISSUE_OP_I == PRD_OP_UNPACK_LO) ||
                    (ISSUE_OP_I == PRD_OP_LOAD) ||
                    (ISSUE_OP_I == PRD_OP_LEGACY_WR);
   wire take = ISSUE_VALID_I && ISSUE_READY_O;

   // approximation operand: low lane of source, broadcast
   wire [REG_W-1:0] src_a = is_approx ? {opb[31:0], opb[31:0]} : opa;
   wire [REG_W-1:0] src_b = opb;
   wire [REG_W-1:0] fp_res;

   // two identical lanes, each independent
   genvar g;
   generate
      for (g = 0; g < 2; g++) begin : g_lane
         prd_lane u_lane (
            .op_i(ISSUE_OP_I),
            .a_i(src_a[g*LANE_W +: LANE_W]),
            .b_i(src_b[g*LANE_W +: LANE_W]),
            .res_o(fp_res[g*LANE_W +: LANE_W])
         );
      end
   endgenerate

   // four signed 16x16 products summed pairwise
   logic signed [31:0] wp [4];
   generate
      for (g = 0; g < 4; g++) begin : g_wmul
         assign wp[g] = $signed(opa[g*16 +: 16]) * $signed(opb[g*16 +: 16]);
      end
   endgenerate
   wire [REG_W-1:0] wmadd_res = {32'(wp[3] + wp[2]), 32'(wp[1] + wp[0])};

   wire [REG_W-1:0] arith_res =
      (ISSUE_OP_I == PRD_OP_WMADD) ? wmadd_res : fp_res;
   wire [REG_W-1:0] single_res =
      (ISSUE_OP_I == PRD_OP_UNPACK_LO) ? {opb[31:0], opa[31:0]} :
      ISSUE_LOAD_DATA_I;

   // approx takes 3 cycles, multiplies 4; later stage forwarding
   // of dependents is the issue logic's job
   wire [1:0] wb_stage = is_approx ? 2'(APPROX_LAT - 1) : 2'(MUL_LAT - 1);

   // no switch penalty: issue never stalls; a single write colliding
   // with the retiring pipe slot in the same cycle is dropped
   wire retire = pv_ff[MUL_LAT-1] ||
                 (pv_ff[APPROX_LAT-1] && pshort_ff[APPROX_LAT-1]);
   assign ISSUE_READY_O = 1'b1;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         pv_ff <= '0;
         pshort_ff <= '0;
         for (int i = 0; i < MUL_LAT; i++) begin
            pipe_ff[i] <= REG_RST_VAL;
            pdst_ff[i] <= '0;
         end
      end else begin
         // pipeline timing fixes the sequence latencies
         pv_ff[0] <= take && is_arith;
         pshort_ff[0] <= is_approx;
         pipe_ff[0] <= arith_res;
         pdst_ff[0] <= ISSUE_DST_I;
         for (int i = 1; i < MUL_LAT; i++) begin
            pv_ff[i] <= pv_ff[i-1] &&
                        !(pshort_ff[i-1] && i == APPROX_LAT);
            pshort_ff[i] <= pshort_ff[i-1];
            pipe_ff[i] <= pipe_ff[i-1];
            pdst_ff[i] <= pdst_ff[i-1];
         end
      end
   end

   wire sel_short = pv_ff[APPROX_LAT-1] && pshort_ff[APPROX_LAT-1];
   wire [REG_IDX_W-1:0] ret_idx =
      sel_short ? pdst_ff[APPROX_LAT-1] : pdst_ff[MUL_LAT-1];
   wire [REG_W-1:0] ret_data =
      sel_short ? pipe_ff[APPROX_LAT-1] : pipe_ff[MUL_LAT-1];
   wire single_wr = take && is_single;
   wire unused_stage = ^wb_stage;

   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         for (int i = 0; i < NUM_REGS; i++) begin
            regs_ff[i] <= REG_RST_VAL;
         end
      end else begin
         if (retire) begin
            regs_ff[ret_idx] <= ret_data;
         end
         if (single_wr && !(retire && ret_idx == ISSUE_DST_I)) begin
            regs_ff[ISSUE_DST_I] <= single_res;
         end
      end
   end

   // packed use sets the state, either clear form drops it
   wire nxt_mm_state = (take && (is_arith ||
                         ISSUE_OP_I == PRD_OP_UNPACK_LO ||
                         ISSUE_OP_I == PRD_OP_LOAD)) ? 1'b1 :
                       (take && is_clr) ? 1'b0 : mm_state_ff;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         mm_state_ff <= 1'b0;
      end else begin
         mm_state_ff <= nxt_mm_state;
      end
   end

   logic [REG_W-1:0] rd_ff;
   logic wbv_ff;
   logic [REG_IDX_W-1:0] wbi_ff;
   always_ff @(posedge SYS_CLK_I or negedge RST_N_I) begin
      if (!RST_N_I) begin
         rd_ff <= REG_RST_VAL;
         wbv_ff <= 1'b0;
         wbi_ff <= '0;
      end else begin
         rd_ff <= regs_ff[RD_IDX_I];
         wbv_ff <= retire || (single_wr && !unused_stage) ||
                   (single_wr && unused_stage);
         wbi_ff <= retire ? ret_idx : ISSUE_DST_I;
      end
   end

   assign RD_DATA_O = rd_ff;
   assign MM_STATE_O = mm_state_ff;
   assign BUSY_O = |pv_ff;
   assign WB_VALID_O = wbv_ff;
   assign WB_IDX_O = wbi_ff;
endmodule

// ==== dv/prd_datapath_assertions.sv ====
`timescale 1ns/10ps
module prd_datapath_chk
   import prd_pkg::*;
(
   input wire logic SYS_CLK_I,
   input wire logic RST_N_I,
   input wire logic ISSUE_VALID_I,
   input wire logic [3:0] ISSUE_OP_I,
   input wire logic ISSUE_READY_O,
   input wire logic MM_STATE_O,
   input wire logic BUSY_O,
   input wire logic WB_VALID_O
);
   default clocking cb @(posedge SYS_CLK_I); endclocking
   default disable iff (!RST_N_I);
   wire logic is_rcp = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_RECIP_APPROX);
   wire logic is_rsq = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_RSQRT_APPROX);
   wire logic is_mul = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_FMUL ||
      ISSUE_OP_I == PRD_OP_RECIP_STEP1 || ISSUE_OP_I == PRD_OP_RECIP_STEP2);
   wire logic is_wmd = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_WMADD);
   wire logic is_ld = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_LOAD);
   wire logic is_lg = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_LEGACY_WR);
   wire logic is_clr = ISSUE_VALID_I && (ISSUE_OP_I == PRD_OP_STATE_CLR ||
      ISSUE_OP_I == PRD_OP_FAST_CLR);
   property p_ready; ISSUE_READY_O; endproperty
   property p_rcp; is_rcp |-> ##[3:4] WB_VALID_O; endproperty
   property p_rsq; is_rsq |-> ##[3:4] WB_VALID_O; endproperty
   property p_mul; is_mul |=> BUSY_O ##[3:4] WB_VALID_O; endproperty
   property p_wmd; is_wmd |-> ##[4:5] WB_VALID_O; endproperty
   property p_lg; is_lg |-> ##[1:2] WB_VALID_O; endproperty
   property p_ld; is_ld |-> ##[1:2] MM_STATE_O; endproperty
   property p_clr; is_clr |-> ##[1:2] !MM_STATE_O; endproperty
   a_ready: assert property (p_ready) else $error("ready low");
   a_rcp: assert property (p_rcp) else $error("recip latency");
   a_rsq: assert property (p_rsq) else $error("rsqrt latency");
   a_mul: assert property (p_mul) else $error("mul latency");
   a_wmd: assert property (p_wmd) else $error("wmadd latency");
   a_lg: assert property (p_lg) else $error("legacy write");
   a_ld: assert property (p_ld) else $error("state not set");
   a_clr: assert property (p_clr) else $error("state not clear");
   c_rcp: cover property (is_rcp);
   c_wmd: cover property (is_wmd);
   c_clr: cover property (is_clr);
endmodule

bind prd_datapath prd_datapath_chk i_prd_datapath_chk (
   .SYS_CLK_I(SYS_CLK_I), .RST_N_I(RST_N_I),
   .ISSUE_VALID_I(ISSUE_VALID_I), .ISSUE_OP_I(ISSUE_OP_I),
   .ISSUE_READY_O(ISSUE_READY_O), .MM_STATE_O(MM_STATE_O),
   .BUSY_O(BUSY_O), .WB_VALID_O(WB_VALID_O));

// ==== dv/prd_issue_model.sv ====
`timescale 1ns/10ps
// issue logic stand-in: one request, held over its take edge
module prd_issue_model
   import prd_pkg::*;
(
   input wire logic clk_i,
   output logic valid_o,
   output logic [3:0] op_o,
   output logic [REG_IDX_W-1:0] dst_o,
   output logic [REG_IDX_W-1:0] src_o,
   output logic [REG_W-1:0] data_o
);
   initial begin
      valid_o = 1'b0;
      op_o = 4'h0;
      dst_o = 3'h0;
      src_o = 3'h0;
      data_o = 64'h0;
   end
   task automatic issue(input logic [3:0] op, input logic [2:0] d, s,
                        input logic [63:0] v);
      @(posedge clk_i);
      valid_o <= 1'b1;
      op_o <= op;
      dst_o <= d;
      src_o <= s;
      data_o <= v;
      @(posedge clk_i);
      valid_o <= 1'b0;
      // stale data must not look valid
      data_o <= ~v;
   endtask
endmodule

// ==== dv/packed_recip_rsqrt_datapath_tb.sv ====
`timescale 1ns/10ps
module packed_recip_rsqrt_datapath_tb;
   import prd_pkg::*;
   logic sys_clk = 1'b0;
   logic rst_n = 1'b0;
   logic [2:0] rd_idx = 3'h0;
   logic vld, rdy, mm, busy, wbv;
   logic [3:0] op;
   logic [2:0] dst, src, wbi;
   logic [63:0] ld, rdd, r;
   int error_cnt = 0;
   int checked = 0;
   always #4 sys_clk = ~sys_clk;
   prd_issue_model i_prd_issue_model (.clk_i(sys_clk), .valid_o(vld),
      .op_o(op), .dst_o(dst), .src_o(src), .data_o(ld));
   prd_datapath i_prd_datapath (.SYS_CLK_I(sys_clk), .RST_N_I(rst_n),
      .ISSUE_VALID_I(vld), .ISSUE_OP_I(op), .ISSUE_DST_I(dst),
      .ISSUE_SRC_I(src), .ISSUE_LOAD_DATA_I(ld), .ISSUE_READY_O(rdy),
      .RD_IDX_I(rd_idx), .RD_DATA_O(rdd), .MM_STATE_O(mm),
      .BUSY_O(busy), .WB_VALID_O(wbv), .WB_IDX_O(wbi));
   task automatic test_done;
      $display("checks %0d errors %0d", checked, error_cnt);
      if (error_cnt == 0 && checked > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask
   task automatic check(input string nm, input logic [63:0] seen, exp);
      checked++;
      if (seen !== exp) begin
         error_cnt++;
         $display("mismatch %s exp %h seen %h", nm, exp, seen);
      end
   endtask
   function automatic logic near(input logic [63:0] a, b, input int t);
      int lo;
      int hi;
      lo = int'(a[31:0]) - int'(b[31:0]);
      hi = int'(a[63:32]) - int'(b[63:32]);
      return lo <= t && lo >= -t && hi <= t && hi >= -t;
   endfunction
   // issue one op and wait for its write-back
   task automatic run(input logic [3:0] c, input logic [2:0] d, s,
                      input logic [63:0] v);
      int n;
      n = 0;
      i_prd_issue_model.issue(c, d, s, v);
      #1;
      while (n < 8 && wbv !== 1'b1) begin
         @(posedge sys_clk);
         #1;
         n++;
      end
      if (wbv !== 1'b1) begin
         error_cnt++;
         test_done();
      end else begin
         check("wb_idx", 64'(wbi), 64'(d));
      end
   endtask
   task automatic rd(input logic [2:0] i, output logic [63:0] v);
      @(posedge sys_clk);
      rd_idx <= i;
      repeat (2) @(posedge sys_clk);
      #1;
      v = rdd;
   endtask
   task automatic t_mul;
      run(PRD_OP_LOAD, 3'h1, 3'h0, 64'h40000000_40400000);
      run(PRD_OP_LOAD, 3'h2, 3'h0, 64'h40800000_3f000000);
      run(PRD_OP_FMUL, 3'h1, 3'h2, 64'h0);
      @(posedge sys_clk);
      #1;
      check("busy", 64'(busy), 64'h0);
      rd(3'h1, r);
      check("fmul", r, 64'h41000000_3fc00000);
   endtask
   task automatic t_div;
      run(PRD_OP_LOAD, 3'h0, 3'h0, 64'h3f800000_40800000);
      run(PRD_OP_RECIP_APPROX, 3'h3, 3'h0, 64'h0);
      rd(3'h3, r);
      check("rcp_est", 64'(near(r, {2{32'h3e800000}}, 512)), 64'h1);
      run(PRD_OP_LOAD, 3'h4, 3'h0, {2{32'h40800000}});
      run(PRD_OP_RECIP_STEP1, 3'h4, 3'h3, 64'h0);
      run(PRD_OP_RECIP_STEP2, 3'h4, 3'h3, 64'h0);
      rd(3'h4, r);
      check("rcp_fine", 64'(near(r, {2{32'h3e800000}}, 1)), 64'h1);
      run(PRD_OP_LOAD, 3'h5, 3'h0, 64'h40400000_3f800000);
      run(PRD_OP_FMUL, 3'h5, 3'h4, 64'h0);
      rd(3'h5, r);
      check("quot", 64'(near(r, 64'h3f400000_3e800000, 1)), 64'h1);
   endtask
   task automatic t_sqrt;
      run(PRD_OP_LOAD, 3'h0, 3'h0, 64'h0_40800000);
      run(PRD_OP_RSQRT_APPROX, 3'h1, 3'h0, 64'h0);
      rd(3'h1, r);
      check("rsq_est", 64'(near(r, {2{32'h3f000000}}, 256)), 64'h1);
      run(PRD_OP_UNPACK_LO, 3'h0, 3'h0, 64'h0);
      rd(3'h0, r);
      check("unpack", r, {2{32'h40800000}});
      run(PRD_OP_FMUL, 3'h0, 3'h1, 64'h0);
      rd(3'h0, r);
      check("sqrt", 64'(near(r, {2{32'h40000000}}, 512)), 64'h1);
      run(PRD_OP_RSQRT_STEP1, 3'h1, 3'h1, 64'h0);
      rd(3'h1, r);
      check("rsq_step", 64'(near(r, {2{32'h3e800000}}, 512)), 64'h1);
   endtask
   task automatic t_wmadd;
      run(PRD_OP_LOAD, 3'h6, 3'h0, 64'hffff0002_80000003);
      run(PRD_OP_LOAD, 3'h7, 3'h0, 64'h00057fff_00020004);
      run(PRD_OP_WMADD, 3'h6, 3'h7, 64'h0);
      rd(3'h6, r);
      check("wmadd", r, 64'h0000fff9_ffff000c);
   endtask
   task automatic t_share;
      run(PRD_OP_LEGACY_WR, 3'h7, 3'h0, 64'h3ff00000_0000abcd);
      rd(3'h7, r);
      check("legacy", r, 64'h3ff00000_0000abcd);
      check("ready", 64'(rdy), 64'h1);
      run(PRD_OP_LOAD, 3'h2, 3'h0, 64'h1);
      check("mm_set", 64'(mm), 64'h1);
      i_prd_issue_model.issue(PRD_OP_STATE_CLR, 3'h0, 3'h0, 64'h0);
      @(posedge sys_clk);
      #1;
      check("mm_clr", 64'(mm), 64'h0);
      run(PRD_OP_LOAD, 3'h2, 3'h0, 64'h2);
      i_prd_issue_model.issue(PRD_OP_FAST_CLR, 3'h0, 3'h0, 64'h0);
      @(posedge sys_clk);
      #1;
      check("mm_fclr", 64'(mm), 64'h0);
      rd(3'h7, r);
      check("kept", r, 64'h3ff00000_0000abcd);
   endtask
   initial begin
      repeat (20) @(posedge sys_clk);
      rst_n <= 1'b1;
      t_mul();
      t_div();
      t_sqrt();
      t_wmadd();
      t_share();
      test_done();
   end
endmodule
